// ---- core/dhp_bus_port.v ----
// Host bus port of the dual-channel UART: bus style decode, access sequencing, pins
`timescale 1ns/1ps
`default_nettype none
`include "dhp_defines.vh"
module dhp_bus_port
(
  input wire clk,
  input wire rst_b,
  input wire bus_style_strap,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire chan_a_select_n,
  input wire chan_b_select_n,
  input wire [2:0] addr,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output reg data_oe,
  output reg reg_rd,
  output reg reg_wr,
  output reg reg_chan,
  output reg [2:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata_a,
  input wire [7:0] reg_rdata_b,
  output reg style_strobe,
  input wire chan_a_irq,
  input wire chan_b_irq,
  input wire chan_a_op2_enable,
  input wire chan_b_op2_enable,
  input wire chan_a_tx_status,
  input wire chan_a_rx_status,
  input wire chan_b_tx_status,
  input wire chan_b_rx_status,
  output wire chan_a_interrupt_o,
  output wire chan_a_interrupt_oe,
  output wire chan_b_interrupt_o,
  output wire chan_b_interrupt_oe,
  output wire chan_a_output_port2_n,
  output wire chan_b_output_port2_n,
  output wire chan_a_tx_ready_n,
  output wire chan_a_rx_ready_n,
  output wire chan_b_tx_ready_n,
  output wire chan_b_rx_ready_n
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [7:0] pick_byte;
    input chan;
    input [7:0] byte_a;
    input [7:0] byte_b;
    begin
      pick_byte = (chan == `DHP_CHAN_B) ? byte_b : byte_a;
    end
  endfunction

  function pick_bit;
    input chan;
    input bit_a;
    input bit_b;
    begin
      pick_bit = (chan == `DHP_CHAN_B) ? bit_b : bit_a;
    end
  endfunction

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  reg strap_taken_q;

  // Strap is sampled once at the first edge after reset release
  // Bus style select
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_taken_q <= 1'b0;
      style_strobe <= `DHP_STYLE_RESET;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      style_strobe <= (bus_style_strap == `DHP_STYLE_STROBE);
    end
  end

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  wire rd_fall;
  wire rd_rise;
  wire wr_fall;
  wire wr_rise;
  wire csa_fall;
  wire csa_rise;

  dhp_edge_det u_rd_edge
  (
    .clk(clk),
    .rst_b(rst_b),
    .sig_n(read_strobe_n),
    .fall(rd_fall),
    .rise(rd_rise)
  );

  dhp_edge_det u_wr_edge
  (
    .clk(clk),
    .rst_b(rst_b),
    .sig_n(write_strobe_n),
    .fall(wr_fall),
    .rise(wr_rise)
  );

  dhp_edge_det u_csa_edge
  (
    .clk(clk),
    .rst_b(rst_b),
    .sig_n(chan_a_select_n),
    .fall(csa_fall),
    .rise(csa_rise)
  );

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  reg start_rd;
  reg start_wr;
  reg start_chan;
  reg access_end;
  reg strobe_sel;
  reg [1:0] state_q;
  reg [1:0] state_d;

  // Channel A wins if the host lowers both selects at once
  always @*
  begin
    start_rd = 1'b0;
    start_wr = 1'b0;
    start_chan = `DHP_CHAN_A;
    access_end = 1'b0;
    strobe_sel = ~chan_a_select_n | ~chan_b_select_n;
    if (style_strobe)
    begin
      start_chan = chan_a_select_n ? `DHP_CHAN_B : `DHP_CHAN_A;
      start_rd = rd_fall & strobe_sel;
      start_wr = wr_fall & strobe_sel & ~start_rd;
      access_end = (state_q == `DHP_ST_WR_HOLD) ? wr_rise : rd_rise;
    end
    else
    begin
      start_chan = (chan_b_select_n == 1'b1) ? `DHP_CHAN_B : `DHP_CHAN_A;
      start_rd = csa_fall & (write_strobe_n == `DHP_DIR_READ);
      start_wr = csa_fall & (write_strobe_n == `DHP_DIR_WRITE);
      access_end = csa_rise;
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `DHP_ST_IDLE:
      begin
        if (start_rd)
        begin
          state_d = `DHP_ST_RD_REQ;
        end
        else if (start_wr)
        begin
          state_d = `DHP_ST_WR_HOLD;
        end
      end
      `DHP_ST_RD_REQ:
      begin
        // A strobe shorter than two cycles drops the drive phase
        state_d = access_end ? `DHP_ST_IDLE : `DHP_ST_RD_DRIVE;
      end
      `DHP_ST_RD_DRIVE:
      begin
        if (access_end)
        begin
          state_d = `DHP_ST_IDLE;
        end
      end
      `DHP_ST_WR_HOLD:
      begin
        if (access_end)
        begin
          state_d = `DHP_ST_IDLE;
        end
      end
      default:
      begin
        state_d = `DHP_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= `DHP_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Register side strobes and data bus
  // ----------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_chan <= `DHP_CHAN_A;
      reg_addr <= `DHP_ADDR_RESET;
      reg_wdata <= `DHP_DATA_RESET;
      data_o <= `DHP_DATA_RESET;
      data_oe <= 1'b0;
    end
    else
    begin
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      if (state_q == `DHP_ST_IDLE && (start_rd || start_wr))
      begin
        // Address and channel latched at start
        reg_chan <= start_chan;
        reg_addr <= addr;
        reg_rd <= start_rd;
      end
      if (state_q == `DHP_ST_WR_HOLD)
      begin
        // Keep the last byte seen before the closing edge
        if (!access_end)
        begin
          reg_wdata <= data_i;
        end
        reg_wr <= access_end;
      end
      if (state_q == `DHP_ST_RD_REQ && !access_end)
      begin
        data_o <= pick_byte(reg_chan, reg_rdata_a, reg_rdata_b);
        data_oe <= 1'b1;
      end
      else if (state_q != `DHP_ST_RD_DRIVE || access_end)
      begin
        data_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Channel pins
  // ----------------------------------------
  wire any_irq;

  // The shared pin carries both channels in direction-line style
  assign any_irq = pick_bit(`DHP_CHAN_A, chan_a_irq, chan_b_irq) | pick_bit(`DHP_CHAN_B, chan_a_irq, chan_b_irq);

  dhp_chan_pins u_pins_a
  (
    .clk(clk),
    .rst_b(rst_b),
    .od_mode(~style_strobe),
    .od_assert(any_irq),
    .op2_enable(chan_a_op2_enable),
    .irq(chan_a_irq),
    .tx_status(chan_a_tx_status),
    .rx_status(chan_a_rx_status),
    .int_o(chan_a_interrupt_o),
    .int_oe(chan_a_interrupt_oe),
    .output_port2_n(chan_a_output_port2_n),
    .tx_ready_n(chan_a_tx_ready_n),
    .rx_ready_n(chan_a_rx_ready_n)
  );

  dhp_chan_pins u_pins_b
  (
    .clk(clk),
    .rst_b(rst_b),
    .od_mode(1'b0),
    .od_assert(1'b0),
    .op2_enable(chan_b_op2_enable),
    .irq(chan_b_irq),
    .tx_status(chan_b_tx_status),
    .rx_status(chan_b_rx_status),
    .int_o(chan_b_interrupt_o),
    .int_oe(chan_b_interrupt_oe),
    .output_port2_n(chan_b_output_port2_n),
    .tx_ready_n(chan_b_tx_ready_n),
    .rx_ready_n(chan_b_rx_ready_n)
  );

endmodule
`default_nettype wire

// ---- common/dhp_defines.vh ----
// Constants for the dual-channel UART host bus port
// What this block does
// - A high bus style strap picks the strobe style bus and a low strap picks the direction-line style.
// - In strobe style a falling read strobe starts a read of the register at the address lines, and the byte is driven until the strobe rises.
// - In strobe style a falling write strobe opens a write, and the rising edge writes the bus byte into the addressed register.
// - In direction-line style the write strobe pin is a direction line, high for read and low for write, and the read strobe is ignored.
// - In strobe style a low first chip select gives access to channel A only.
// - In strobe style a low second chip select gives access to channel B only.
// - In direction-line style the first chip select is the single active-low select for every access.
// - In direction-line style the second chip select pin is a channel address bit, 0 for channel A and 1 for channel B.
// - In strobe style the channel A interrupt is driven and output port 2 is low while its enable bit is 1, else the interrupt floats and port 2 is high.
// - In direction-line style the channel A interrupt pin is a device-wide active-low open-drain interrupt.
// - The channel B interrupt is driven and its output port 2 is low while its enable bit is 1, else it floats and port 2 is high.
// - Each channel has an active-low transmitter ready output that follows its transmit status.
// - Each channel has an active-low receiver ready output that follows its receive status.
// - Three address lines select a register of the addressed channel in each transaction.
// - Register bytes pass over an eight-bit two-way data bus that the device drives only during reads.
`ifndef DHP_DEFINES_VH
`define DHP_DEFINES_VH

// ----------------------------------------
// Bus style strap values
// ----------------------------------------
`define DHP_STYLE_STROBE 1'b1
`define DHP_STYLE_DIRLINE 1'b0
`define DHP_STYLE_RESET 1'b1

// ----------------------------------------
// Direction line and channel codes
// ----------------------------------------
`define DHP_DIR_READ 1'b1
`define DHP_DIR_WRITE 1'b0
`define DHP_CHAN_A 1'b0
`define DHP_CHAN_B 1'b1

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define DHP_ADDR_W 3
`define DHP_DATA_W 8
`define DHP_ADDR_RESET 3'h0
`define DHP_DATA_RESET 8'h00

// ----------------------------------------
// Access state codes
// ----------------------------------------
`define DHP_ST_W 2
`define DHP_ST_IDLE 2'h0
`define DHP_ST_RD_REQ 2'h1
`define DHP_ST_RD_DRIVE 2'h2
`define DHP_ST_WR_HOLD 2'h3

`endif

// ---- core/dhp_edge_det.v ----
// Edge detector for one synchronous active-low bus input
`timescale 1ns/1ps
`default_nettype none
module dhp_edge_det
(
  input wire clk,
  input wire rst_b,
  input wire sig_n,
  output wire fall,
  output wire rise
);

  reg prev_q;

  // Idle level of every bus strobe and select is high
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_q <= 1'b1;
    end
    else
    begin
      prev_q <= sig_n;
    end
  end

  assign fall = prev_q & ~sig_n;
  assign rise = ~prev_q & sig_n;

endmodule
`default_nettype wire

// ---- core/dhp_chan_pins.v ----
// Per-channel interrupt, output port 2 and ready pins
`timescale 1ns/1ps
`default_nettype none
module dhp_chan_pins
(
  input wire clk,
  input wire rst_b,
  input wire od_mode,
  input wire od_assert,
  input wire op2_enable,
  input wire irq,
  input wire tx_status,
  input wire rx_status,
  output reg int_o,
  output reg int_oe,
  output reg output_port2_n,
  output reg tx_ready_n,
  output reg rx_ready_n
);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      int_o <= 1'b0;
      int_oe <= 1'b0;
      output_port2_n <= 1'b1;
      tx_ready_n <= 1'b1;
      rx_ready_n <= 1'b1;
    end
    else
    begin
      if (od_mode)
      begin
        int_o <= 1'b0;
        int_oe <= od_assert;
      end
      else
      begin
        int_o <= irq;
        int_oe <= op2_enable;
      end
      // Port 2 tracks the enable bit even when the pin is open drain
      output_port2_n <= ~op2_enable;
      tx_ready_n <= ~tx_status;
      rx_ready_n <= ~rx_status;
    end
  end

endmodule
`default_nettype wire

// ---- verification/dhp_bus_port_props.sv ----
// Concurrent checks on the host bus port pins
`timescale 1ns/1ps
`default_nettype none
module dhp_bus_port_props
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic style_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic data_oe,
  input wire logic chan_a_irq,
  input wire logic chan_b_irq,
  input wire logic chan_a_op2_enable,
  input wire logic chan_b_op2_enable,
  input wire logic chan_a_tx_status,
  input wire logic chan_b_rx_status,
  input wire logic chan_a_interrupt_o,
  input wire logic chan_a_interrupt_oe,
  input wire logic chan_b_interrupt_oe,
  input wire logic chan_b_output_port2_n,
  input wire logic chan_a_tx_ready_n,
  input wire logic chan_b_rx_ready_n
);
  // ----------------------------------------
  // Bus and pin properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rd_drives_bus: assert property (reg_rd && style_strobe && !read_strobe_n |=> data_oe)
    else $error("read did not drive the bus");
  a_oe_drops: assert property (data_oe && (style_strobe ? read_strobe_n : chan_a_select_n) |=> !data_oe)
    else $error("bus still driven after strobe rose");
  a_oe_from_read: assert property ($rose(data_oe) |-> $past(reg_rd))
    else $error("bus driven without a read");
  a_sel_gates_rd: assert property (reg_rd && style_strobe |-> $past(!chan_a_select_n || !chan_b_select_n))
    else $error("read without a select");
  a_dir_read: assert property (reg_rd && !style_strobe |-> $past(!chan_a_select_n && write_strobe_n))
    else $error("direction read without select or read level");
  a_wr_closes: assert property (reg_wr |-> $past(style_strobe ? write_strobe_n : chan_a_select_n))
    else $error("write before closing edge");
  a_chan_a_interrupt_gated: assert property ((style_strobe ##1 style_strobe) |->
    chan_a_interrupt_oe == $past(chan_a_op2_enable) && chan_a_interrupt_o == $past(chan_a_irq))
    else $error("channel A interrupt gating wrong");
  a_chan_a_interrupt_od: assert property ((!style_strobe ##1 !style_strobe) |->
    !chan_a_interrupt_o && chan_a_interrupt_oe == $past(chan_a_irq || chan_b_irq))
    else $error("open drain interrupt wrong");
  a_chan_b_interrupt_gated: assert property ($past(rst_b) |->
    chan_b_interrupt_oe == $past(chan_b_op2_enable) && chan_b_output_port2_n == !$past(chan_b_op2_enable))
    else $error("channel B interrupt gating wrong");
  a_ready_level: assert property ($past(rst_b) |->
    chan_a_tx_ready_n == !$past(chan_a_tx_status) && chan_b_rx_ready_n == !$past(chan_b_rx_status))
    else $error("ready outputs wrong");
endmodule
bind dhp_bus_port dhp_bus_port_props u_props (.*);
`default_nettype wire

// ---- verification/dhp_host_model.sv ----
// Host processor model on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model
(
  input wire logic clk,
  input wire logic bus_style_strap,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  output logic [2:0] addr,
  output logic [7:0] data_i
);
  logic [7:0] hd;
  // ----------------------------------------
  // Bus wire and access task
  // ----------------------------------------
  // device drives on reads
  assign data_i = data_oe ? data_o : hd;
  initial
  begin
    {read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n} = 4'hf;
    addr = 3'h0;
    hd = 8'h00;
  end
  task automatic acc(input logic rd, input logic [1:0] sel, input logic [2:0] a, input logic [7:0] wd,
    input int n, output logic [7:0] rv);
    @(negedge clk);
    addr = a;
    hd = wd;
    if (bus_style_strap)
      {chan_b_select_n, chan_a_select_n} = sel;
    else
    begin
      chan_b_select_n = sel[0];
      write_strobe_n = rd;
    end
    @(negedge clk);
    if (!bus_style_strap)
      chan_a_select_n = 1'b0;
    else if (rd)
      read_strobe_n = 1'b0;
    else
      write_strobe_n = 1'b0;
    repeat (n) @(negedge clk);
    rv = data_i;
    if (bus_style_strap)
      {read_strobe_n, write_strobe_n} = 2'b11;
    else
      chan_a_select_n = 1'b1;
    @(negedge clk);
    // Released lines show the inverse so stale data cannot pass
    {chan_b_select_n, chan_a_select_n, write_strobe_n} = 3'h7;
    hd = ~hd;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- verification/test_dual_uart_host_bus_port.sv ----
// Self-checking bench for the dual UART host bus port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module test_dual_uart_host_bus_port;
  logic clk, rst_b, bus_style_strap;
  logic [7:0] pin;
  logic [11:0] wlog;
  int err_total = 0;
  int samples_checked = 0;
  int nrd = 0;
  wire read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n, data_oe, reg_rd, reg_wr, reg_chan;
  wire style_strobe, chan_a_irq, chan_b_irq, chan_a_op2_enable, chan_b_op2_enable;
  wire chan_a_tx_status, chan_a_rx_status, chan_b_tx_status, chan_b_rx_status;
  wire chan_a_interrupt_o, chan_a_interrupt_oe, chan_b_interrupt_o, chan_b_interrupt_oe;
  wire chan_a_output_port2_n, chan_b_output_port2_n;
  wire chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n;
  wire [2:0] addr, reg_addr;
  wire [7:0] data_i, data_o, reg_wdata, reg_rdata_a, reg_rdata_b;
  // ----------------------------------------
  // Register side stand-in and pins
  // ----------------------------------------
  assign reg_rdata_a = {5'h15, reg_addr};
  assign reg_rdata_b = {5'h0a, reg_addr};
  assign {chan_b_rx_status, chan_b_tx_status, chan_a_rx_status, chan_a_tx_status,
    chan_b_op2_enable, chan_a_op2_enable, chan_b_irq, chan_a_irq} = pin;
  always @(posedge clk)
  begin
    if (reg_rd)
      nrd <= nrd + 1;
    if (reg_wr)
      wlog <= {reg_chan, reg_addr, reg_wdata};
  end
  dhp_bus_port DUT (.*);
  dhp_host_model host (.*);
  always #50 clk = ~clk;
  task give_verdict;
    $display("Checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task t_strobe;
    logic [7:0] v;
    int n;
    `CHK("style_s", 1'b1, style_strobe)
    host.acc(1'b0, 2'b10, 3'h5, 8'h3c, 2, v);
    `CHK("wr_a", 12'h53c, wlog)
    host.acc(1'b0, 2'b01, 3'h2, 8'hc3, 5, v);
    `CHK("wr_b", 12'hac3, wlog)
    host.acc(1'b1, 2'b10, 3'h3, 8'h00, 2, v);
    `CHK("rd_a", 8'hab, v)
    host.acc(1'b1, 2'b01, 3'h7, 8'h00, 5, v);
    `CHK("rd_b", 8'h57, v)
    `CHK("oe", 1'b0, data_oe)
    n = nrd;
    host.acc(1'b1, 2'b11, 3'h0, 8'h00, 3, v);
    host.acc(1'b0, 2'b11, 3'h4, 8'h99, 3, v);
    `CHK("nosel", {n, 12'hac3}, {nrd, wlog})
  endtask
  task t_pins;
    logic [3:0] k;
    for (int i = 0; i < 16; i++)
    begin
      k = i[3:0];
      @(negedge clk);
      pin = {~k, k};
      repeat (2) @(negedge clk);
      `CHK("ia_o", k[0], chan_a_interrupt_o)
      `CHK("ia_oe", k[2], chan_a_interrupt_oe)
      `CHK("pa_n", ~k[2], chan_a_output_port2_n)
      `CHK("ib", {k[1], k[3]}, {chan_b_interrupt_o, chan_b_interrupt_oe})
      `CHK("pb_n", ~k[3], chan_b_output_port2_n)
      `CHK("rdy", k, {chan_b_rx_ready_n, chan_b_tx_ready_n, chan_a_rx_ready_n, chan_a_tx_ready_n})
    end
  endtask
  task t_dir;
    logic [7:0] v;
    @(negedge clk);
    rst_b = 1'b0;
    bus_style_strap = 1'b0;
    pin = 8'h02;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("style", 1'b0, style_strobe)
    `CHK("irq_od", 2'b01, {chan_a_interrupt_o, chan_a_interrupt_oe})
    host.acc(1'b0, 2'b00, 3'h1, 8'h5a, 2, v);
    `CHK("dwr_a", 12'h15a, wlog)
    host.acc(1'b1, 2'b01, 3'h6, 8'h00, 5, v);
    `CHK("drd_b", 8'h56, v)
  endtask
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    bus_style_strap = 1'b1;
    pin = 8'h00;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_strobe();
    t_pins();
    t_dir();
    give_verdict();
  end
  // Whole run needs under 300 cycles; allow ten times that
  initial
  begin
    #300000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
